// file: common/fpc_cfg.svh
// register offsets, control fields, reset values for the flash prefetch cache
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
`define FPC_OFS_CTRL 8'h00
`define FPC_OFS_SEL 8'h04
`define FPC_OFS_TAG 8'h08
`define FPC_OFS_MASK 8'h0C
`define FPC_OFS_WORD0 8'h10
`define FPC_CTRL_RST 32'h0000_0007
`define FPC_CTRL_WMASK 32'h0001_0337
`define FPC_COH_BIT 16
`define FPC_DATA_LINE_COUNT_HI 9
`define FPC_DATA_LINE_COUNT_LO 8
`define FPC_PREF_HI 5
`define FPC_PREF_LO 4
`define FPC_WS_HI 2
`define FPC_WS_LO 0
`define FPC_TAG_LOCK_BIT 1
`define FPC_TAG_VALID_BIT 0
`endif

// file: common/fpc_pkg.sv
// shared types of the flash prefetch cache
// assumes nothing beyond a systemverilog compiler
package fpc_pkg;
  typedef enum logic [2:0] {
    FPC_IDLE = 3'b001,
    FPC_FILL = 3'b010,
    FPC_PREF = 3'b100
  } fpc_state_e;
endpackage

// file: common/fpc_core_if.sv
// links the cache core to its flash line reader and its replacement logic
// assumes all three modules share one clock
interface fpc_core_if #(parameter int LINES = 16);
  logic start;
  logic [27:0] line_addr;
  logic [2:0] wait_states;
  logic done;
  logic [127:0] line;
  logic touch;
  logic [$clog2(LINES)-1:0] touch_idx;
  logic [LINES-1:0] allow;
  logic [LINES-1:0] valid;
  logic [$clog2(LINES)-1:0] victim;
  logic found;
  modport core (output start, line_addr, wait_states, touch, touch_idx, allow, valid,
    input done, line, victim, found);
  modport rd (input start, line_addr, wait_states, output done, line);
  modport lru (input touch, touch_idx, allow, valid, output victim, found);
endinterface

// file: rtl/fpc_flash_rd.sv
// 16-byte program flash line reader with programmable wait states
// assumes flash data is valid after the address has been held wait_states+1 cycles
`include "fpc_cfg.svh"
module fpc_flash_rd (
  input wire logic clk,
  input wire logic rst_b,
  fpc_core_if.rd fi,
  output logic flash_rd,
  output logic [27:0] flash_line_addr,
  input wire logic [127:0] flash_rdata
);
  typedef struct packed {
    logic busy;
    logic [2:0] cnt;
    logic rd;
    logic [27:0] addr;
    logic done;
    logic [127:0] line;
  } fpc_rd_s;
  fpc_rd_s s, n;

  // one address phase, then a whole line in one parallel fetch
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (!s.busy && fi.start) begin
      n.busy = 1'b1;
      // RULE12: wait states loaded
      n.cnt = fi.wait_states;
      n.rd = 1'b1;
      n.addr = fi.line_addr;
    end else if (s.busy) begin
      if (s.cnt == 3'h0) begin
        // RULE3: full line sampled
        n.line = flash_rdata;
        n.done = 1'b1;
        n.busy = 1'b0;
        n.rd = 1'b0;
      end else begin
        n.cnt = s.cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign fi.done = s.done;
  assign fi.line = s.line;
  assign flash_rd = s.rd;
  assign flash_line_addr = s.addr;
endmodule

// file: rtl/fpc_plru.sv
// pseudo least-recently-used victim choice, one recently-used bit per line
// assumes the core passes only lines it may replace in allow (locks removed)
module fpc_plru #(
  parameter int LINES = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  fpc_core_if.lru li
);
  typedef struct packed {
    logic [LINES-1:0] mru;
  } fpc_lru_s;
  fpc_lru_s s, n;
  logic [LINES-1:0] pick_inv, pick_old, pick_any;

  // three priority levels: empty line, not recently used, anything allowed
  generate
    for (genvar i = 0; i < LINES; i++) begin : g_pick
      assign pick_inv[i] = li.allow[i] && !li.valid[i];
      assign pick_old[i] = li.allow[i] && !s.mru[i];
      assign pick_any[i] = li.allow[i];
    end
  endgenerate

  // RULE6: victim choice
  always_comb begin
    li.victim = '0;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (pick_any[i]) begin
        li.victim = i[$clog2(LINES)-1:0];
      end
    end
    for (int i = LINES - 1; i >= 0; i--) begin
      if (pick_old[i] && (pick_inv == '0)) begin
        li.victim = i[$clog2(LINES)-1:0];
      end
    end
    for (int i = LINES - 1; i >= 0; i--) begin
      if (pick_inv[i]) begin
        li.victim = i[$clog2(LINES)-1:0];
      end
    end
  end
  assign li.found = |li.allow;

  // age all others once every allowed line has been used
  always_comb begin
    logic [LINES-1:0] upd;
    upd = s.mru;
    n = s;
    if (li.touch) begin
      upd[li.touch_idx] = 1'b1;
      n.mru = upd;
      // locked, masked or unused lines must not hold back the aging
      if (&(upd | ~li.allow)) begin
        n.mru = '0;
        n.mru[li.touch_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// file: rtl/fpc_cache.sv
// flash prefetch cache core: lookup, fill, prefetch, coherency and register slave
// assumes cpu_req holds address and flags until cpu_ready, and flash_prog is a pulse
`include "fpc_cfg.svh"
// Operation
// RULE1: instructions and constant data from cacheable flash are cached, and instructions are prefetched.
// RULE2: there are 16 fully associative lines, each of which can be locked.
// RULE3: each line is 16 bytes and is filled by one parallel flash fetch.
// RULE4: at most four lines ever hold constant data, the rest hold instructions.
// RULE5: two lines have an address mask so one line can match a range of addresses.
// RULE6: a pseudo least-recently-used choice picks the victim, never a locked line.
// RULE7: software can write every line, its tag and its contents.
// RULE8: a flash programming cycle drops all lines if coherency is set, else data and unlocked lines.
// RULE9: the data line count field selects 4, 2, 1 or no data lines.
// RULE10: a write that changes the data line count field invalidates every line.
// RULE11: the prefetch field enables prefetch for both, non-cacheable, cacheable or no regions.
// RULE12: the wait state field adds that many clock cycles to every flash access.
// RULE13: unimplemented control bits read as zero and should be written as zero.
// RULE14: a miss stalls the fetch until the line read ends, then fills and returns the word.
// RULE15: a hit returns the word with no flash wait states.
module fpc_cache #(
  parameter int LINES = 16,
  parameter int MASKED = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_req,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_data,
  input wire logic cpu_cacheable,
  output logic cpu_ready,
  output logic [31:0] cpu_rdata,
  input wire logic flash_prog,
  output logic flash_rd,
  output logic [27:0] flash_line_addr,
  input wire logic [127:0] flash_rdata
);
  localparam int IW = $clog2(LINES);

  generate
    if (LINES != 16 || MASKED < 1 || MASKED > LINES - 8) begin : g_bad
      $error("fpc_cache: unsupported LINES or MASKED");
    end
  endgenerate

  typedef struct packed {
    fpc_pkg::fpc_state_e st;
    logic [31:0] ctrl;
    logic [IW-1:0] sel;
    logic [LINES-1:0] valid;
    logic [LINES-1:0] lock;
    logic [LINES-1:0][27:0] tag;
    logic [LINES-1:0][27:0] amask;
    logic [LINES-1:0][127:0] data;
    logic nc_valid;
    logic [27:0] nc_tag;
    logic [127:0] nc_data;
    logic pf_pend;
    logic pf_nc;
    logic [27:0] pf_tag;
    logic [27:0] fill_tag;
    logic [1:0] fill_word;
    logic fill_alloc;
    logic fill_nc;
    logic [IW-1:0] fill_line;
    logic pf_arm;
    logic pf_arm_nc;
    logic start;
    logic cpu_ready;
    logic [31:0] cpu_rdata;
    logic waitreq;
    logic [31:0] rdata;
  } fpc_main_s;
  fpc_main_s s, n;

  fpc_core_if #(.LINES(LINES)) ci ();

  fpc_flash_rd u_rd (
    .clk(clk),
    .rst_b(rst_b),
    .fi(ci.rd),
    .flash_rd(flash_rd),
    .flash_line_addr(flash_line_addr),
    .flash_rdata(flash_rdata)
  );

  fpc_plru #(.LINES(LINES)) u_lru (
    .clk(clk),
    .rst_b(rst_b),
    .li(ci.lru)
  );

  // RULE2: fully associative compare
  // RULE5: masked bits of the top lines are ignored
  function automatic logic [IW:0] fpc_match(input fpc_main_s st, input logic [27:0] t);
    logic [IW:0] r;
    r = '0;
    for (int i = 0; i < LINES; i++) begin
      if (st.valid[i] && (((st.tag[i] ^ t) & ~st.amask[i]) == 28'h0)) begin
        r = {1'b1, i[IW-1:0]};
      end
    end
    return r;
  endfunction

  logic [LINES-1:0] dmask;
  logic [LINES-1:0] allow_ins;
  logic [LINES-1:0] allow_dat;

  // RULE4: data lines sit at the bottom, four at most
  // RULE9: line count decode
  always_comb begin
    dmask = '0;
    case (s.ctrl[`FPC_DATA_LINE_COUNT_HI:`FPC_DATA_LINE_COUNT_LO])
      2'b11: dmask[3:0] = 4'hF;
      2'b10: dmask[1:0] = 2'h3;
      2'b01: dmask[0] = 1'b1;
      default: dmask = '0;
    endcase
    // masked lines are filled by software only
    allow_ins = ~dmask & ~s.lock;
    allow_ins[LINES-1 -: MASKED] = '0;
    allow_dat = dmask & ~s.lock;
  end

  // replacement picks for the lookup running this cycle
  assign ci.valid = s.valid;
  // RULE4: a prefetch in the answer cycle never takes a data line
  assign ci.allow = (s.st == fpc_pkg::FPC_IDLE && cpu_req && cpu_data && !s.cpu_ready) ?
    allow_dat : allow_ins;
  assign ci.start = s.start;
  assign ci.line_addr = s.fill_tag;
  assign ci.wait_states = s.ctrl[`FPC_WS_HI:`FPC_WS_LO];

  always_comb begin
    logic [27:0] a_tag;
    logic [IW:0] hm;
    logic [IW:0] pm;
    logic pf_ok;
    logic [1:0] pref;
    logic [31:0] rv;
    logic [31:0] bm;
    logic [31:0] mg;
    a_tag = cpu_addr[31:4];
    hm = fpc_match(s, a_tag);
    pm = fpc_match(s, s.pf_tag);
    pref = s.ctrl[`FPC_PREF_HI:`FPC_PREF_LO];
    // RULE11: region gate for prefetch
    pf_ok = !cpu_data && (cpu_cacheable ? pref[0] : pref[1]);
    rv = 32'h0;
    bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    n = s;
    n.start = 1'b0;
    n.cpu_ready = 1'b0;
    ci.touch = 1'b0;
    ci.touch_idx = hm[IW-1:0];

    // fetch side
    case (s.st)
      fpc_pkg::FPC_IDLE: begin
        if (cpu_req && !s.cpu_ready) begin
          if (cpu_cacheable && hm[IW]) begin
            // RULE15: hit served next cycle
            n.cpu_ready = 1'b1;
            n.cpu_rdata = s.data[hm[IW-1:0]][cpu_addr[3:2]*32 +: 32];
            ci.touch = 1'b1;
            n.pf_pend = pf_ok;
            n.pf_nc = 1'b0;
            n.pf_tag = a_tag + 28'h1;
          end else if (!cpu_cacheable && !cpu_data && s.nc_valid && s.nc_tag == a_tag) begin
            n.cpu_ready = 1'b1;
            n.cpu_rdata = s.nc_data[cpu_addr[3:2]*32 +: 32];
            n.pf_pend = pf_ok;
            n.pf_nc = 1'b1;
            n.pf_tag = a_tag + 28'h1;
          end else begin
            // RULE14: miss stalls for the line read
            n.st = fpc_pkg::FPC_FILL;
            n.start = 1'b1;
            n.fill_tag = a_tag;
            n.fill_word = cpu_addr[3:2];
            // RULE1: only cacheable fetches take a line
            n.fill_alloc = cpu_cacheable && ci.found;
            n.fill_nc = !cpu_cacheable && !cpu_data && pref[1];
            n.fill_line = ci.victim;
            n.pf_arm = pf_ok;
            n.pf_arm_nc = !cpu_cacheable;
            n.pf_pend = 1'b0;
          end
        end else if (s.pf_pend) begin
          n.pf_pend = 1'b0;
          // RULE1: predictive fetch of the next line
          if (!(s.pf_nc ? (s.nc_valid && s.nc_tag == s.pf_tag) : pm[IW])) begin
            n.st = fpc_pkg::FPC_PREF;
            n.start = 1'b1;
            n.fill_tag = s.pf_tag;
            n.fill_alloc = !s.pf_nc && ci.found;
            n.fill_nc = s.pf_nc;
            n.fill_line = ci.victim;
          end
        end
      end
      fpc_pkg::FPC_FILL, fpc_pkg::FPC_PREF: begin
        if (ci.done) begin
          n.st = fpc_pkg::FPC_IDLE;
          if (s.st == fpc_pkg::FPC_FILL) begin
            n.cpu_ready = 1'b1;
            n.cpu_rdata = ci.line[s.fill_word*32 +: 32];
            n.pf_pend = s.pf_arm;
            n.pf_nc = s.pf_arm_nc;
            n.pf_tag = s.fill_tag + 28'h1;
          end
          if (s.fill_alloc) begin
            n.valid[s.fill_line] = 1'b1;
            n.tag[s.fill_line] = s.fill_tag;
            n.data[s.fill_line] = ci.line;
            ci.touch = 1'b1;
            ci.touch_idx = s.fill_line;
          end
          if (s.fill_nc) begin
            n.nc_valid = 1'b1;
            n.nc_tag = s.fill_tag;
            n.nc_data = ci.line;
          end
        end
      end
      default: n.st = fpc_pkg::FPC_IDLE;
    endcase

    // RULE8: coherency on a flash program cycle
    if (flash_prog) begin
      for (int i = 0; i < LINES; i++) begin
        if (dmask[i] || s.ctrl[`FPC_COH_BIT] || !s.lock[i]) begin
          n.valid[i] = 1'b0;
        end
      end
      n.nc_valid = 1'b0;
      n.pf_pend = 1'b0;
      n.fill_alloc = 1'b0;
      n.fill_nc = 1'b0;
    end

    // register read view
    case (avs_address)
      // RULE13: unimplemented bits read zero
      `FPC_OFS_CTRL: rv = s.ctrl;
      `FPC_OFS_SEL: rv[IW-1:0] = s.sel;
      `FPC_OFS_TAG: rv = {s.tag[s.sel], 2'b00, s.lock[s.sel], s.valid[s.sel]};
      `FPC_OFS_MASK: rv = {s.amask[s.sel], 4'h0};
      default: rv = 32'h0;
    endcase
    for (int k = 0; k < 4; k++) begin
      if (avs_address == `FPC_OFS_WORD0 + 8'(4 * k)) begin
        rv = s.data[s.sel][k*32 +: 32];
      end
    end
    mg = (rv & ~bm) | (avs_writedata & bm);

    // avalon slave: answer one cycle after the request appears
    if ((avs_read || avs_write) && s.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = avs_read ? rv : 32'h0;
    end else begin
      n.waitreq = 1'b1;
      if (avs_write && !s.waitreq) begin
        case (avs_address)
          `FPC_OFS_CTRL: begin
            // RULE10: new line count drops every line
            if (mg[`FPC_DATA_LINE_COUNT_HI:`FPC_DATA_LINE_COUNT_LO] != s.ctrl[`FPC_DATA_LINE_COUNT_HI:`FPC_DATA_LINE_COUNT_LO]) begin
              n.valid = '0;
              n.nc_valid = 1'b0;
              n.pf_pend = 1'b0;
              n.fill_alloc = 1'b0;
              n.fill_nc = 1'b0;
            end
            // RULE13: only implemented bits stored
            n.ctrl = mg & `FPC_CTRL_WMASK;
          end
          `FPC_OFS_SEL: n.sel = mg[IW-1:0];
          // RULE7: direct tag and flag write
          `FPC_OFS_TAG: begin
            n.tag[s.sel] = mg[31:4];
            n.lock[s.sel] = mg[`FPC_TAG_LOCK_BIT];
            n.valid[s.sel] = mg[`FPC_TAG_VALID_BIT];
          end
          // RULE5: masks exist on the top lines only
          `FPC_OFS_MASK: begin
            if (s.sel >= IW'(LINES - MASKED)) begin
              n.amask[s.sel] = mg[31:4];
            end
          end
          default: begin
            // RULE7: direct content write
            for (int k = 0; k < 4; k++) begin
              if (avs_address == `FPC_OFS_WORD0 + 8'(4 * k)) begin
                n.data[s.sel][k*32 +: 32] = mg;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
      s.st <= fpc_pkg::FPC_IDLE;
      s.ctrl <= `FPC_CTRL_RST;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // every output straight from a flop
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign cpu_ready = s.cpu_ready;
  assign cpu_rdata = s.cpu_rdata;
endmodule

// file: tb/fpc_cache_monitor.sv
// port checker of the flash prefetch cache: bus answers, line reads, fetch answers
// assumes it is bound to fpc_cache and sees only the top ports
`include "fpc_cfg.svh"
module fpc_cache_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic cpu_req,
  input wire logic cpu_ready,
  input wire logic flash_rd,
  input wire logic [27:0] flash_line_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ws_q;
  logic [1:0] pref_q;
  logic [3:0] run_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of wait states and prefetch field; length of the running line read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ws_q <= 3'h7;
      pref_q <= 2'h0;
      run_q <= 4'h0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0]) begin
        ws_q <= avs_writedata[2:0];
        pref_q <= avs_writedata[5:4];
      end
      run_q <= flash_rd ? run_q + 4'h1 : 4'h0;
    end
  end
  a_bus_answers: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ctrl_unused_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h00
    |-> (avs_readdata & ~`FPC_CTRL_WMASK) == 32'h0000_0000)
    else $error("unimplemented control bits read nonzero");
  a_read_length: assert property ($fell(flash_rd) |-> run_q == {1'b0, ws_q} + 4'h1)
    else $error("line read length differs from wait states plus one");
  a_line_addr_held: assert property (flash_rd && $past(flash_rd) |-> $stable(flash_line_addr))
    else $error("line address moved during a read");
  a_miss_answer: assert property ($fell(flash_rd) && cpu_req && !cpu_ready && pref_q == 2'h0
    |=> cpu_ready)
    else $error("miss not answered right after the line read");
  a_ready_pulse: assert property (cpu_ready |=> !cpu_ready)
    else $error("fetch answer longer than one cycle");
  a_ready_cause: assert property (cpu_ready |-> $past(cpu_req))
    else $error("fetch answer without a request");
  // main scenarios reached
  c_line_read: cover property ($fell(flash_rd));
  c_fast_hit: cover property (cpu_req && !cpu_ready && !flash_rd ##1 cpu_ready);
  c_reg_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind fpc_cache fpc_cache_monitor i_mon (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_ready(cpu_ready),
  .flash_rd(flash_rd), .flash_line_addr(flash_line_addr));

// file: tb/fpc_flash_model.sv
// program flash behind the cache: answers a whole line from its address
// assumes the cache samples data only on the last cycle of flash_rd
module fpc_flash_model (
  input wire logic clk,
  input wire logic flash_rd,
  input wire logic [27:0] flash_line_addr,
  output logic [127:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] junk_q = 128'h0;
  // pattern changes every cycle so stale data never looks valid
  always @(posedge clk) junk_q <= ~junk_q;
  always_comb begin
    flash_rdata = junk_q;
    if (flash_rd) begin
      for (int k = 0; k < 4; k++) flash_rdata[32*k +: 32] = {flash_line_addr[25:0], 4'hC, 2'(k)};
    end
  end
endmodule

// file: tb/fpc_cache_test.sv
// self-checking bench of the flash prefetch cache
// assumes the flash model and the bound port checker beside the design
module fpc_cache_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, avs_read, avs_write, cpu_req, cpu_data, cpu_cacheable, flash_prog;
  logic avs_waitrequest, cpu_ready, flash_rd;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, cpu_addr, cpu_rdata, a, r;
  logic [27:0] flash_line_addr;
  logic [127:0] flash_rdata;
  logic [31:0] exp_cpu[$], exp_reg[$];
  int err_total, num_checks, cyc, lat, miss;
  fpc_cache i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_cacheable(cpu_cacheable),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .flash_prog(flash_prog),
    .flash_rd(flash_rd), .flash_line_addr(flash_line_addr), .flash_rdata(flash_rdata));
  fpc_flash_model i_flash (.clk(clk), .flash_rd(flash_rd), .flash_line_addr(flash_line_addr),
    .flash_rdata(flash_rdata));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] fw(input logic [31:0] ad);
    return {ad[29:4], 4'hC, ad[3:2]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] ad, input logic [31:0] ex);
    exp_reg.push_back(ex);
    bus(1'b0, ad, 32'h0000_0000);
  endtask
  // fetch held until cpu_ready; latency counted from the taking edge
  task automatic fetch(input logic [31:0] ad, input logic dat, input logic [31:0] ed, input int el);
    exp_cpu.push_back(ed);
    @(posedge clk);
    cpu_addr <= ad;
    cpu_data <= dat;
    cpu_req <= 1'b1;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (cpu_ready !== 1'b1);
    cpu_req <= 1'b0;
    lat = lat - 1;
    if (el >= 0) check(lat, el);
  endtask
  task automatic idle();
    repeat (2) @(posedge clk);
    // a running prefetch must end before the next request
    while (flash_rd !== 1'b0) @(posedge clk);
  endtask
  task automatic prog_pulse();
    @(posedge clk);
    flash_prog <= 1'b1;
    @(posedge clk);
    flash_prog <= 1'b0;
  endtask
  // result watcher: oldest note against each answer
  always @(negedge clk) begin
    if (cpu_ready === 1'b1) check(cpu_rdata, exp_cpu.pop_front());
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, exp_reg.pop_front());
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {rst_b, avs_read, avs_write, cpu_req, cpu_data, flash_prog} = 6'h00;
    {avs_address, avs_writedata, cpu_addr} = 72'h0;
    avs_byteenable = 4'hF;
    cpu_cacheable = 1'b1;
    void'($urandom(92));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdx(8'h00, 32'h0000_0007);
    // software keeps unimplemented control bits at zero
    bus(1'b1, 8'h00, 32'h0001_0337);
    rdx(8'h00, 32'h0001_0337);
    rdx(8'h40, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0000);
    for (int w = 0; w < 8; w++) begin
      bus(1'b1, 8'h00, w);
      a = 32'h1000 + 16 * w + 4 * ($urandom % 4);
      fetch(a, 1'b0, fw(a), w + 4);
      fetch(a, 1'b0, fw(a), 1);
    end
    bus(1'b1, 8'h00, 32'h0000_0000);
    for (int i = 0; i < 28; i++) fetch(32'h1000 + 16 * (i % 14), 1'b0, fw(32'h1000 + 16 * (i % 14)),
      (i < 8 || i > 13) ? 1 : 4);
    bus(1'b1, 8'h00, 32'h0000_0100);
    fetch(32'h1000, 1'b0, fw(32'h1000), 4);
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, 8'h00, d << 8);
      a = 32'h2000 + 16 * d;
      fetch(a, 1'b1, fw(a), 4);
      fetch(a, 1'b1, fw(a), d > 0 ? 1 : 4);
    end
    miss = 0;
    for (int i = 0; i < 10; i++) begin
      fetch(32'h3000 + 16 * (i % 5), 1'b1, fw(32'h3000 + 16 * (i % 5)), i < 5 ? 4 : -1);
      if (i >= 5 && lat > 1) miss++;
    end
    check(miss > 0, 1);
    r = $urandom;
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_0003);
    bus(1'b1, 8'h08, 32'h0000_5003);
    for (int k = 0; k < 4; k++) bus(1'b1, 8'h10 + 8'(4 * k), r + k);
    fetch(32'h5008, 1'b0, r + 2, 1);
    prog_pulse();
    fetch(32'h5008, 1'b0, r + 2, 1);
    bus(1'b1, 8'h00, 32'h0001_0000);
    prog_pulse();
    fetch(32'h5008, 1'b0, fw(32'h5008), 4);
    bus(1'b1, 8'h04, 32'h0000_000E);
    bus(1'b1, 8'h08, 32'h0000_6001);
    bus(1'b1, 8'h0C, 32'h0000_0010);
    for (int k = 0; k < 4; k++) bus(1'b1, 8'h10 + 8'(4 * k), r ^ k);
    fetch(32'h6004, 1'b0, r ^ 1, 1);
    fetch(32'h6014, 1'b0, r ^ 1, 1);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, 8'h00, p << 4);
      a = 32'h7000 + 64 * p;
      fetch(a, 1'b0, fw(a), 4);
      idle();
      fetch(a + 16, 1'b0, fw(a + 16), p[0] ? 1 : 4);
      idle();
    end
    // non-cacheable stream buffer: filled on a miss and by prefetch, never a cache line
    cpu_cacheable <= 1'b0;
    bus(1'b1, 8'h00, 32'h0000_0020);
    fetch(32'h8000, 1'b0, fw(32'h8000), 4);
    idle();
    fetch(32'h8014, 1'b0, fw(32'h8014), 1);
    idle();
    fetch(32'h8000, 1'b0, fw(32'h8000), 4);
    test_done();
  end
endmodule
